// [rtl/pia_pkg.sv]
/*
  Constants and carrier types for the PHY identification and advertisement register bank.
  Assumes a 32-bit APB with byte addresses equal to four times the management index.
*/
package pia_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned IDX_IDENT_HIGH = 2;
  localparam int unsigned IDX_IDENT_LOW = 3;
  localparam int unsigned IDX_ADVERT = 4;
  localparam logic [11:0] ADDR_IDENT_HIGH = 12'(IDX_IDENT_HIGH * 4);
  localparam logic [11:0] ADDR_IDENT_LOW = 12'(IDX_IDENT_LOW * 4);
  localparam logic [11:0] ADDR_ADVERT = 12'(IDX_ADVERT * 4);
  localparam logic [11:0] ADDR_LOAD_DATA = 12'h020;
  localparam logic [11:0] ADDR_LOAD_CTRL = 12'h024;

  // ---------------------------------------------------------------------------
  // Reset values (identity values are arbitrary)
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_IDENT_HIGH = 16'h1234;
  localparam logic [5:0] RST_ORG_BITS = 6'h2A;
  localparam logic [5:0] RST_MODEL = 6'h05;
  localparam logic [3:0] RST_REVISION = 4'h3;
  localparam logic [4:0] RST_SELECTOR = 5'h01;

  // ---------------------------------------------------------------------------
  // Advertisement field positions, writable mask and load control bits
  // ---------------------------------------------------------------------------
  localparam int unsigned ADV_REMOTE_FAULT = 13;
  localparam int unsigned ADV_RSVD_RW = 12;
  localparam int unsigned ADV_ASYM_PAUSE = 11;
  localparam int unsigned ADV_SYM_PAUSE = 10;
  localparam int unsigned ADV_FD100 = 8;
  localparam int unsigned ADV_HD100 = 7;
  localparam int unsigned ADV_FD10 = 6;
  localparam int unsigned ADV_HD10 = 5;
  localparam logic [15:0] ADV_WRITABLE = 16'h3DFF;
  localparam int unsigned LOAD_CTRL_RELOAD = 0;
  localparam int unsigned LOAD_CTRL_BUSY = 1;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic autoneg;
    logic speed;
    logic duplex;
    logic manual_flow_ctrl_pin_setting;
  } pia_strap_t;

  typedef struct packed {
    logic [5:0] org_bits;
    logic [5:0] model;
    logic [3:0] revision;
  } pia_ident_low_t;
endpackage

// [rtl/pia_regs.sv]
/*
  APB register bank for one port: identification words and the advertisement word,
  with strap-derived defaults and a loader overwrite path.
  Assumes straps are static pins and the loader presents a word with a load strobe.
*/
// The implementer's own choice: the APB interface to the registers.

module pia_regs
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire pia_pkg::pia_strap_t strap_in,
  input wire logic load_valid_in,
  input wire logic [15:0] load_word_in,
  output logic reload_req_out,
  output logic [15:0] advert_out
);
  // ---------------------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------------------
  pia_pkg::pia_strap_t strap_sync;
  pia_pkg::pia_strap_t strap_r;
  logic in_reset_r;
  logic rel_r;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      pia_sync3 u_sync
      (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .clk_en_in(clk_en_in),
        .pin_in(strap_in[gi]),
        .level_out(strap_sync[gi])
      );
    end
  endgenerate

  // Straps are caught a few cycles after release, once the synchronisers have filled.
  logic [2:0] settle_r;
  wire logic settle_done = (settle_r == 3'h4);

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      settle_r <= 3'h0;
      in_reset_r <= 1'b1;
      strap_r <= '0;
    end
    else if (clk_en_in)
    begin
      if (!settle_done)
      begin
        settle_r <= settle_r + 3'h1;
      end
      if (in_reset_r && settle_done)
      begin
        strap_r <= strap_sync;
        in_reset_r <= 1'b0;
      end
    end
  end

  assign rel_r = in_reset_r && settle_done;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire logic acc = psel_in && penable_in;
  wire logic wr = acc && pwrite_in;
  wire logic hit_hi = (paddr_in == pia_pkg::ADDR_IDENT_HIGH);
  wire logic hit_lo = (paddr_in == pia_pkg::ADDR_IDENT_LOW);
  wire logic hit_adv = (paddr_in == pia_pkg::ADDR_ADVERT);
  wire logic hit_ld = (paddr_in == pia_pkg::ADDR_LOAD_DATA);
  wire logic hit_lc = (paddr_in == pia_pkg::ADDR_LOAD_CTRL);
  wire logic hit_any = hit_hi || hit_lo || hit_adv || hit_ld || hit_lc;
  wire logic lanes_ok = (pstrb_in[1:0] == 2'h3) || !pwrite_in;
  wire logic [15:0] wdata = pwdata_in[15:0];
  wire logic wr_ok = wr && lanes_ok;

  assign pready_out = 1'b1;
  assign pslverr_out = acc && (!hit_any || !lanes_ok);

  // ---------------------------------------------------------------------------
  // Identification words
  // ---------------------------------------------------------------------------
  logic [15:0] ident_hi_r;
  pia_pkg::pia_ident_low_t ident_lo_r;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      ident_hi_r <= pia_pkg::RST_IDENT_HIGH;
      ident_lo_r <= {pia_pkg::RST_ORG_BITS, pia_pkg::RST_MODEL, pia_pkg::RST_REVISION};
    end
    else if (clk_en_in)
    begin
      if (wr_ok && hit_hi)
      begin
        ident_hi_r <= wdata;
      end
      if (wr_ok && hit_lo)
      begin
        ident_lo_r <= wdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Advertisement word
  // ---------------------------------------------------------------------------
  logic [15:0] adv_r;
  logic [15:0] adv_nxt;
  logic [15:0] adv_dflt;
  logic [15:0] load_word_r;
  logic reload_busy_r;
  logic load_pend_r;

  // Defaults built from the synchronised straps (strap_sync); unsupported abilities have no bit.
  always_comb
  begin
    adv_dflt = '0;
    adv_dflt[pia_pkg::ADV_REMOTE_FAULT] = 1'b0;
    adv_dflt[pia_pkg::ADV_ASYM_PAUSE] = 1'b0;
    adv_dflt[pia_pkg::ADV_SYM_PAUSE] = !strap_sync.manual_flow_ctrl_pin_setting;
    adv_dflt[pia_pkg::ADV_FD100] = 1'b1;
    adv_dflt[pia_pkg::ADV_HD100] = 1'b1;
    adv_dflt[pia_pkg::ADV_FD10] = strap_sync.autoneg || (!strap_sync.speed && strap_sync.duplex);
    adv_dflt[pia_pkg::ADV_HD10] = strap_sync.autoneg || !strap_sync.speed;
    adv_dflt[4:0] = pia_pkg::RST_SELECTOR;
  end

  // The loader image replaces the writable bits, reserved bit 12 included; bits 15:14 and 9 stay zero.
  wire logic [15:0] load_img = (load_valid_in ? load_word_in : load_word_r)
    & pia_pkg::ADV_WRITABLE;

  always_comb
  begin
    adv_nxt = adv_r;
    if (rel_r)
    begin
      adv_nxt = adv_dflt;
    end
    else if (load_valid_in || load_pend_r)
    begin
      adv_nxt = load_img;
    end
    else if (wr_ok && hit_adv)
    begin
      adv_nxt = wdata & pia_pkg::ADV_WRITABLE;
    end
  end

  wire logic reload_cmd = wr_ok && hit_lc && wdata[pia_pkg::LOAD_CTRL_RELOAD];

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      adv_r <= {2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0, pia_pkg::RST_SELECTOR};
      load_word_r <= 16'h0000;
      reload_busy_r <= 1'b0;
      load_pend_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      adv_r <= adv_nxt;
      if (wr_ok && hit_ld)
      begin
        load_word_r <= wdata;
      end
      // After the straps settle the loader image is applied once, as after reset release.
      load_pend_r <= rel_r;
      if (reload_cmd)
      begin
        reload_busy_r <= 1'b1;
      end
      else if (load_valid_in)
      begin
        reload_busy_r <= 1'b0;
      end
    end
  end

  assign reload_req_out = reload_busy_r || rel_r;
  assign advert_out = adv_r;

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  wire logic [15:0] rd_mux = hit_hi ? ident_hi_r :
    hit_lo ? ident_lo_r :
    hit_adv ? adv_r :
    hit_ld ? load_word_r :
    hit_lc ? {14'h0000, reload_busy_r, 1'b0} : 16'h0000;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      prdata_out <= 32'h0000_0000;
    end
    else if (clk_en_in && psel_in && !penable_in && !pwrite_in)
    begin
      prdata_out <= {16'h0000, rd_mux};
    end
  end

  // ---------------------------------------------------------------------------
  // Bus, identification and clock enable checks
  // ---------------------------------------------------------------------------
  // Writes land at the access edge and reads are latched at the setup edge.
  a_lo_write: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && wr_ok && hit_lo)
    |=> (ident_lo_r == $past(wdata)))
    else $error("ident low write lost");

  a_hi_write: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && wr_ok && hit_hi)
    |=> (ident_hi_r == $past(wdata)))
    else $error("ident high write lost");

  a_bad_lane: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && acc && pwrite_in && !lanes_ok)
    |=> ($stable(ident_lo_r) && $stable(ident_hi_r)))
    else $error("refused write changed an ident word");

  a_read_low: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && psel_in && !penable_in && !pwrite_in && hit_lo)
    |=> (prdata_out == {16'h0000, $past(ident_lo_r)}))
    else $error("ident low read data wrong");

  a_read_advert: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && psel_in && !penable_in && !pwrite_in && hit_adv)
    |=> (prdata_out == {16'h0000, $past(advert_out)}))
    else $error("advert read data wrong");

  // A low enable must hold the advertisement, both identification words, the reload request and the read data.
  a_enable_freeze: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !clk_en_in
    |=> ($stable(advert_out) && $stable(ident_lo_r) && $stable(ident_hi_r)
    && $stable(prdata_out) && $stable(reload_req_out)))
    else $error("state moved while clock enable low");

  // ---------------------------------------------------------------------------
  // Advertisement and reload checks
  // ---------------------------------------------------------------------------
  // The loader outranks software, so writes are checked only when no load is due.
  a_reserved_zero: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (advert_out[15:14] == 2'h0) && !advert_out[9])
    else $error("reserved bits set");

  a_adv_write: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && wr_ok && hit_adv && !rel_r && !load_valid_in && !load_pend_r)
    |=> (advert_out == ($past(wdata) & 16'h3DFF)))
    else $error("advert write lost");

  a_load_over: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && load_valid_in && !rel_r)
    |=> (advert_out == ($past(load_word_in) & 16'h3DFF)))
    else $error("loader image not applied");

  a_pause_load: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && load_valid_in && !rel_r)
    |=> (((advert_out ^ $past(load_word_in)) & 16'h0C00) == 16'h0000))
    else $error("pause bits not loaded");

  a_start_load: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && load_pend_r && !load_valid_in)
    |=> (advert_out == ($past(load_word_r) & 16'h3DFF)))
    else $error("startup load not applied");

  a_busy_clear: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && load_valid_in && !reload_cmd)
    |=> !reload_busy_r)
    else $error("reload busy not cleared");

  a_reload_busy: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && reload_cmd)
    |=> reload_req_out)
    else $error("reload not requested");

  // ---------------------------------------------------------------------------
  // Strap latch and default checks
  // ---------------------------------------------------------------------------
  // Defaults are checked one edge after the straps are caught.
  a_strap_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !in_reset_r
    |=> $stable(strap_r))
    else $error("latched straps changed");

  a_dflt_fd10: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && rel_r)
    |=> (advert_out[6] == (strap_r.autoneg || (!strap_r.speed && strap_r.duplex))))
    else $error("fd10 default");

  a_dflt_hd10: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && rel_r)
    |=> (advert_out[5] == (strap_r.autoneg || !strap_r.speed)))
    else $error("hd10 default");

  a_dflt_sym: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && rel_r)
    |=> (advert_out[10] == !strap_r.manual_flow_ctrl_pin_setting))
    else $error("sym pause default");

  a_dflt_fixed: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (clk_en_in && rel_r)
    |=> ((advert_out[13:11] == 3'h0) && advert_out[8] && advert_out[7]
    && (advert_out[4:0] == 5'h01)))
    else $error("fixed defaults");
endmodule

// [rtl/pia_sync3.sv]
/*
  Three-flop synchroniser with agreement filter for a single pin.
  Assumes the pin is asynchronous to ref_clk_in.
*/
module pia_sync3
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  wire logic agree = (s2_r == s3_r);

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree)
      begin
        level_out <= s3_r;
      end
    end
  end
endmodule

// [test/pia_regs_tb.sv]
/*
  Self-checking bench for the identification and advertisement register bank.
  Assumes a zero-wait APB slave and a loader that hands over a word with a one-cycle strobe.
*/
module pia_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, reload_req, load_valid = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] load_word = 16'h0000, advert;
  pia_pkg::pia_strap_t strap = '0;
  int failures = 0, comparisons = 0, m_low, m_adv, m_high;
  logic [31:0] rd;
  logic err;
  always #50 ref_clk_in = ~ref_clk_in;
  pia_regs dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .clk_en_in(clk_en), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .strap_in(strap), .load_valid_in(load_valid), .load_word_in(load_word),
    .reload_req_out(reload_req), .advert_out(advert));
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    input logic [3:0] st);
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Default advertisement word worked out from the strap pins.
  function automatic logic [15:0] adv_default(input logic [3:0] s);
    return {5'h00, ~s[0], 1'b0, 2'b11, s[3] | (~s[2] & s[1]), s[3] | ~s[2], 5'h01};
  endfunction
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    complete_run();
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    logic [15:0] prev, cur, w;
    int n;
    void'($urandom(99893));
    for (int s = 0; s < 16; s++)
    begin
      strap <= s[3:0];
      srst_in <= 1'b1;
      repeat (12) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      cur = 16'h0181;
      n = 0;
      do
      begin
        @(posedge ref_clk_in);
        prev = cur;
        cur = advert;
        n++;
      end
      while (cur !== 16'h0000 && n < 30);
      chk({16'h0, prev}, {16'h0, adv_default(s[3:0])});
      chk({16'h0, cur}, 32'h0);
    end
    $display("strap default test done");
    m_low = {pia_pkg::RST_ORG_BITS, pia_pkg::RST_MODEL, pia_pkg::RST_REVISION};
    apb(1'b0, pia_pkg::ADDR_IDENT_HIGH, 32'h0, 4'hF);
    chk(rd, {16'h0, pia_pkg::RST_IDENT_HIGH});
    apb(1'b0, pia_pkg::ADDR_IDENT_LOW, 32'h0, 4'hF);
    chk(rd, m_low);
    for (int i = 0; i < 6; i++)
    begin
      m_low = $urandom & 32'hFFFF;
      apb(1'b1, pia_pkg::ADDR_IDENT_LOW, m_low, 4'h3);
      apb(1'b0, pia_pkg::ADDR_IDENT_LOW, 32'h0, 4'hF);
      chk(rd, m_low);
      m_high = $urandom & 32'hFFFF;
      apb(1'b1, pia_pkg::ADDR_IDENT_HIGH, m_high, 4'hF);
      apb(1'b0, pia_pkg::ADDR_IDENT_HIGH, 32'h0, 4'hF);
      chk(rd, m_high);
      w = (i == 0) ? 16'hEFFF : 16'($urandom) & 16'hEFFF;
      m_adv = w & 16'h3DFF;
      apb(1'b1, pia_pkg::ADDR_ADVERT, {16'h0, w}, 4'h3);
      apb(1'b0, pia_pkg::ADDR_ADVERT, 32'h0, 4'hF);
      chk(rd, m_adv);
      chk({16'h0, advert}, m_adv);
    end
    $display("read write test done");
    apb(1'b0, 12'h0FC, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, pia_pkg::ADDR_IDENT_LOW, 32'h0000FFFF, 4'h1);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, pia_pkg::ADDR_IDENT_LOW, 32'h0, 4'hF);
    chk(rd, m_low);
    $display("refusal test done");
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, pia_pkg::ADDR_LOAD_CTRL, 32'h1, 4'hF);
      @(posedge ref_clk_in);
      chk({31'h0, reload_req}, 32'h1);
      apb(1'b0, pia_pkg::ADDR_LOAD_CTRL, 32'h0, 4'hF);
      chk(rd & 32'h2, 32'h2);
      w = (i == 0) ? 16'h0C00 : 16'($urandom);
      load_word <= w;
      load_valid <= 1'b1;
      @(posedge ref_clk_in);
      load_valid <= 1'b0;
      @(posedge ref_clk_in);
      m_adv = w & 16'h3DFF;
      chk({16'h0, advert}, m_adv);
      chk({31'h0, reload_req}, 32'h0);
    end
    $display("reload test done");
    clk_en <= 1'b0;
    load_word <= ~w;
    load_valid <= 1'b1;
    @(posedge ref_clk_in);
    clk_en <= 1'b1;
    load_valid <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk({16'h0, advert}, m_adv);
    chk({31'h0, reload_req}, 32'h0);
    $display("clock enable test done");
    complete_run();
  end
endmodule
